// File: rtl/timer16_compare_output_modes.sv
// 16-bit timer with counting modes, compare outputs and pin override
`timescale 1ns/1ps

module timer16_compare_output_modes (
    // clock, reset and clock enable
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // capture event and flag service strobes
    input wire logic i_capture_event,
    input wire timer16_pkg::flags_t i_flag_serviced,
    // flags and pins
    output timer16_pkg::flags_t o_flags,
    output logic [1:0] o_pin_out,
    output logic [1:0] o_pin_oe
);
    // registers
    timer16_pkg::ctrl_t ctrl_r;
    timer16_pkg::port_t port_r;
    timer16_pkg::bus_state_t bus_r;
    logic [15:0] count_r;
    logic [15:0] capt_r;
    logic [15:0] cmp_r [timer16_pkg::N_CH];
    logic [15:0] cmp_buf_r [timer16_pkg::N_CH];
    logic block_r;

    // internal signals
    logic tick;
    logic [3:0] ws;
    logic pwm;
    logic fast;
    logic non_pwm;
    logic at_top;
    logic clears;
    logic capt_top;
    logic [15:0] top_val;
    logic wr_go;
    logic [15:0] ctrl_merged;
    logic load_top;
    logic [timer16_pkg::N_CH-1:0] match;
    logic [timer16_pkg::N_CH-1:0] out_bit;
    logic [1:0] action [timer16_pkg::N_CH];
    timer16_pkg::flags_t flag_set;
    timer16_pkg::flags_t flag_clr;

    // twelve pwm codes: everything except 0, 4, 12 and 13
    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = !(m == timer16_pkg::WS_NORMAL || m == timer16_pkg::WS_CLEAR_CMPA ||
                   m == timer16_pkg::WS_CLEAR_CAPT || m == timer16_pkg::WS_NORMAL_ALT);
    endfunction : is_pwm

    // single-slope modes
    function automatic logic is_fast(input logic [3:0] m);
        is_fast = (m == timer16_pkg::WS_FAST_8) || (m == timer16_pkg::WS_FAST_9) ||
                  (m == timer16_pkg::WS_FAST_10) || (m == timer16_pkg::WS_FAST_CAPT) ||
                  (m == timer16_pkg::WS_FAST_CMPA);
    endfunction : is_fast

    // capture register sets top
    function automatic logic top_is_capt(input logic [3:0] m);
        top_is_capt = (m == timer16_pkg::WS_CLEAR_CAPT) || (m == timer16_pkg::WS_FAST_CAPT);
    endfunction : top_is_capt

    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ---------------- mode decode ----------------
    // counting depends on waveform select only
    assign ws = ctrl_r.waveform_select;
    assign pwm = is_pwm(ws);
    assign fast = is_fast(ws);
    assign non_pwm = !pwm;
    assign capt_top = top_is_capt(ws);
    assign clears = fast || ws == timer16_pkg::WS_CLEAR_CMPA ||
                    ws == timer16_pkg::WS_CLEAR_CAPT;

    // top value per mode
    always_comb begin
        case (ws)
            timer16_pkg::WS_CLEAR_CMPA: top_val = cmp_r[0];
            timer16_pkg::WS_CLEAR_CAPT: top_val = capt_r;
            timer16_pkg::WS_FAST_8: top_val = timer16_pkg::TOP_8;
            timer16_pkg::WS_FAST_9: top_val = timer16_pkg::TOP_9;
            timer16_pkg::WS_FAST_10: top_val = timer16_pkg::TOP_10;
            timer16_pkg::WS_FAST_CAPT: top_val = capt_r;
            timer16_pkg::WS_FAST_CMPA: top_val = cmp_r[0];
            default: top_val = timer16_pkg::CNT_MAX;
        endcase
    end

    // a count write also hides any top, fixed or variable, for one tick
    assign at_top = clears && (count_r == top_val) && !block_r;

    // buffered compares reload at top in single-slope, at max in the other pwm modes
    assign load_top = tick && (fast ? at_top : count_r == timer16_pkg::CNT_MAX);

    // ---------------- prescaler ----------------
    timer16_prescaler u_prescaler (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_sel(ctrl_r.clk_sel),
        .o_tick(tick)
    );

    // ---------------- avalon-mm slave ----------------
    // one wait cycle, then waitrequest low for exactly one cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            bus_r <= timer16_pkg::BUS_IDLE;
        end else if (i_ce) begin
            case (bus_r)
                timer16_pkg::BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_r <= timer16_pkg::BUS_ANSWER;
                    end
                end
                timer16_pkg::BUS_ANSWER: bus_r <= timer16_pkg::BUS_IDLE;
                default: bus_r <= timer16_pkg::BUS_IDLE;
            endcase
        end
    end

    // waitrequest from a flop, low only in the answer cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_avs_waitrequest <= 1'b1;
        end else if (i_ce) begin
            o_avs_waitrequest <= !(bus_r == timer16_pkg::BUS_IDLE &&
                                   (i_avs_read || i_avs_write));
        end
    end

    // write takes effect at the edge where waitrequest is seen low
    assign wr_go = i_ce && i_avs_write && bus_r == timer16_pkg::BUS_ANSWER;

    // control word after a byte-lane write, cut to the fields that exist
    assign ctrl_merged = merge16(16'(ctrl_r), i_avs_writedata, i_avs_byteenable);

    // read data captured as the answer is raised; unmapped reads give zero
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_avs_readdata <= '0;
        end else if (i_ce && bus_r == timer16_pkg::BUS_IDLE && i_avs_read) begin
            case (i_avs_address)
                timer16_pkg::OFS_CTRL: o_avs_readdata <= 32'(ctrl_r);
                timer16_pkg::OFS_COUNT: o_avs_readdata <= 32'(count_r);
                timer16_pkg::OFS_CMP_A: o_avs_readdata <= 32'(cmp_buf_r[0]);
                timer16_pkg::OFS_CMP_B: o_avs_readdata <= 32'(cmp_buf_r[1]);
                timer16_pkg::OFS_CAPT: o_avs_readdata <= 32'(capt_r);
                timer16_pkg::OFS_FLAGS: o_avs_readdata <= 32'(o_flags);
                timer16_pkg::OFS_PORT: o_avs_readdata <= 32'(port_r);
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // control and port registers; action fields apply at once, not buffered
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctrl_r <= timer16_pkg::CTRL_RST;
            port_r <= timer16_pkg::PORT_RST;
        end else if (wr_go) begin
            if (i_avs_address == timer16_pkg::OFS_CTRL) begin
                ctrl_r <= ctrl_merged[$bits(timer16_pkg::ctrl_t)-1:0];
            end
            if (i_avs_address == timer16_pkg::OFS_PORT && i_avs_byteenable[0]) begin
                port_r <= i_avs_writedata[$bits(timer16_pkg::port_t)-1:0];
            end
        end
    end

    // ---------------- counter ----------------
    // software write wins over the tick, in any mode
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            count_r <= timer16_pkg::CNT_BOTTOM;
        end else if (wr_go && i_avs_address == timer16_pkg::OFS_COUNT) begin
            count_r <= merge16(count_r, i_avs_writedata, i_avs_byteenable);
        end else if (tick) begin
            if (at_top) begin
                count_r <= timer16_pkg::CNT_BOTTOM;
            end else begin
                count_r <= count_r + 16'h0001; // wraps past max
            end
        end
    end

    // a count write hides matches for the following tick
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            block_r <= 1'b0;
        end else if (wr_go && i_avs_address == timer16_pkg::OFS_COUNT) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // ---------------- compare registers ----------------
    // buffered in pwm modes and loaded at top, direct otherwise
    generate
        for (genvar i = 0; i < timer16_pkg::N_CH; i++) begin : g_cmp
            localparam logic [4:0] OFS = i == 0 ? timer16_pkg::OFS_CMP_A :
                                                 timer16_pkg::OFS_CMP_B;
            logic cmp_wr;
            assign cmp_wr = wr_go && i_avs_address == OFS;

            // buffer always follows software
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    cmp_buf_r[i] <= timer16_pkg::REG16_RST;
                end else if (cmp_wr) begin
                    cmp_buf_r[i] <= merge16(cmp_buf_r[i], i_avs_writedata, i_avs_byteenable);
                end
            end

            // active value used by the comparator
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    cmp_r[i] <= timer16_pkg::REG16_RST;
                end else if (i_ce) begin
                    if (non_pwm && cmp_wr) begin
                        cmp_r[i] <= merge16(cmp_buf_r[i], i_avs_writedata, i_avs_byteenable);
                    end else if (pwm && load_top) begin
                        cmp_r[i] <= cmp_buf_r[i];
                    end
                end
            end

            // match pulse on the tick where count equals compare
            assign match[i] = tick && !block_r && count_r == cmp_r[i];
            assign action[i] = i == 0 ? ctrl_r.action_a : ctrl_r.action_b;

            // output bit of this channel
            timer16_out_channel u_out (
                .i_clk_sys(i_clk_sys),
                .i_rstn(i_rstn),
                .i_ce(i_ce),
                .i_action(action[i]),
                .i_non_pwm(non_pwm),
                .i_fast(fast),
                .i_toggle_ok(i == 0 && ws == timer16_pkg::WS_FAST_CMPA),
                .i_match(match[i]),
                .i_bottom(fast && tick && at_top),
                .i_force(wr_go && i_avs_address == timer16_pkg::OFS_FORCE &&
                         i_avs_writedata[i]),
                .o_bit(out_bit[i])
            );

            // pin: output bit overrides port value when action is nonzero
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    o_pin_out[i] <= 1'b0;
                    o_pin_oe[i] <= 1'b0;
                end else if (i_ce) begin
                    o_pin_out[i] <= action[i] != timer16_pkg::ACT_NONE ?
                                    out_bit[i] : port_r.port_value[i];
                    o_pin_oe[i] <= port_r.output_pin_direction_bit[i];
                end
            end
        end
    endgenerate

    // ---------------- capture register ----------------
    // capture runs on its own event; action fields never reach it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            capt_r <= timer16_pkg::REG16_RST;
        end else if (wr_go && i_avs_address == timer16_pkg::OFS_CAPT) begin
            capt_r <= merge16(capt_r, i_avs_writedata, i_avs_byteenable);
        end else if (i_ce && i_capture_event && !capt_top) begin
            capt_r <= count_r;
        end
    end

    // ---------------- flags ----------------
    // overflow: wrap in normal and clear-on-match, top in fast pwm
    always_comb begin
        flag_set.overflow_flag = tick && (fast ? at_top : count_r == timer16_pkg::CNT_MAX);
        flag_set.compare_a_flag = match[0];
        flag_set.compare_b_flag = match[1];
        flag_set.capture_flag = (tick && capt_top && at_top) ||
                                (i_ce && i_capture_event && !capt_top);
    end

    // write one to clear, or service strobe
    assign flag_clr = i_flag_serviced |
                      ((wr_go && i_avs_address == timer16_pkg::OFS_FLAGS) ?
                       i_avs_writedata[$bits(timer16_pkg::flags_t)-1:0] : '0);

    // set beats clear in the same cycle; hardware never clears
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_flags <= timer16_pkg::FLAGS_RST;
        end else if (i_ce) begin
            o_flags <= (o_flags & ~flag_clr) | flag_set;
        end
    end
endmodule : timer16_compare_output_modes

// File: pkg/timer16_pkg.sv
// shared constants, register map and field types of the 16-bit timer
package timer16_pkg;
    // register byte offsets on the slave bus
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_CMP_A = 5'h08;
    localparam logic [4:0] OFS_CMP_B = 5'h0C;
    localparam logic [4:0] OFS_CAPT = 5'h10;
    localparam logic [4:0] OFS_FLAGS = 5'h14;
    localparam logic [4:0] OFS_FORCE = 5'h18;
    localparam logic [4:0] OFS_PORT = 5'h1C;

    // waveform select codes handled here
    localparam logic [3:0] WS_NORMAL = 4'h0;
    localparam logic [3:0] WS_CLEAR_CMPA = 4'h4;
    localparam logic [3:0] WS_FAST_8 = 4'h5;
    localparam logic [3:0] WS_FAST_9 = 4'h6;
    localparam logic [3:0] WS_FAST_10 = 4'h7;
    localparam logic [3:0] WS_CLEAR_CAPT = 4'hC;
    localparam logic [3:0] WS_NORMAL_ALT = 4'hD;
    localparam logic [3:0] WS_FAST_CAPT = 4'hE;
    localparam logic [3:0] WS_FAST_CMPA = 4'hF;

    // count limits
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;

    // compare output action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam logic [1:0] ACT_PWM_NONINV = 2'h2;
    localparam logic [1:0] ACT_PWM_INV = 2'h3;

    // prescaler select codes and divider masks
    localparam int PRE_W = 10;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [PRE_W-1:0] MASK_DIV1 = 10'h000;
    localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
    localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03F;
    localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0FF;
    localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3FF;

    // number of compare channels
    localparam int N_CH = 2;

    // control register layout, low bits upward: wave, clk_sel, act_a, act_b
    typedef struct packed {
        logic [1:0] action_b;
        logic [1:0] action_a;
        logic [2:0] clk_sel;
        logic [3:0] waveform_select;
    } ctrl_t;

    // event flags, bit 0 is the overflow flag
    typedef struct packed {
        logic capture_flag;
        logic compare_b_flag;
        logic compare_a_flag;
        logic overflow_flag;
    } flags_t;

    // general port value and direction for the two pins, bit 0 is channel a
    typedef struct packed {
        logic [1:0] output_pin_direction_bit;
        logic [1:0] port_value;
    } port_t;

    // bus handshake states
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

    // reset values
    localparam ctrl_t CTRL_RST = '0;
    localparam flags_t FLAGS_RST = '0;
    localparam port_t PORT_RST = '0;
    localparam logic [15:0] REG16_RST = 16'h0000;
endpackage : timer16_pkg

// File: rtl/timer16_prescaler.sv
// prescaler making the timer clock enable from the system clock
`timescale 1ns/1ps
module timer16_prescaler (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    // divider select
    input wire logic [2:0] i_sel,
    // timer tick
    output logic o_tick
);
    logic [timer16_pkg::PRE_W-1:0] pre_r;
    logic [timer16_pkg::PRE_W-1:0] mask;
    logic run;

    // divider mask per select code
    function automatic logic [timer16_pkg::PRE_W-1:0] div_mask(input logic [2:0] sel);
        case (sel)
            timer16_pkg::CS_DIV8: div_mask = timer16_pkg::MASK_DIV8;
            timer16_pkg::CS_DIV64: div_mask = timer16_pkg::MASK_DIV64;
            timer16_pkg::CS_DIV256: div_mask = timer16_pkg::MASK_DIV256;
            timer16_pkg::CS_DIV1024: div_mask = timer16_pkg::MASK_DIV1024;
            default: div_mask = timer16_pkg::MASK_DIV1;
        endcase
    endfunction : div_mask

    // unused select codes stop the timer like code zero
    assign run = (i_sel >= timer16_pkg::CS_DIV1) && (i_sel <= timer16_pkg::CS_DIV1024);
    assign mask = div_mask(i_sel);

    // free divider, held at zero while stopped
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pre_r <= '0;
        end else if (i_ce) begin
            pre_r <= run ? pre_r + 1'b1 : '0;
        end
    end

    // one tick every N system clocks, N of 1, 8, 64, 256 or 1024
    assign o_tick = i_ce && run && ((pre_r & mask) == mask);
endmodule : timer16_prescaler

// File: rtl/timer16_out_channel.sv
// compare output bit of one channel and its reaction to matches
`timescale 1ns/1ps
module timer16_out_channel (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    // configuration
    input wire logic [1:0] i_action,
    input wire logic i_non_pwm,
    input wire logic i_fast,
    input wire logic i_toggle_ok,
    // events
    input wire logic i_match,
    input wire logic i_bottom,
    input wire logic i_force,
    // output bit
    output logic o_bit
);
    logic bit_nxt;

    // next output bit from action field and events
    always_comb begin
        bit_nxt = o_bit;
        if (i_non_pwm && (i_match || i_force)) begin
            // force acts like a real match here
            case (i_action)
                timer16_pkg::ACT_TOGGLE: bit_nxt = !o_bit;
                timer16_pkg::ACT_CLEAR: bit_nxt = 1'b0;
                timer16_pkg::ACT_SET: bit_nxt = 1'b1;
                default: bit_nxt = o_bit; // zero leaves the bit alone
            endcase
        end else if (i_fast) begin
            // match first, bottom last: compare equal to top gives a flat level
            if (i_match) begin
                case (i_action)
                    timer16_pkg::ACT_PWM_NONINV: bit_nxt = 1'b0;
                    timer16_pkg::ACT_PWM_INV: bit_nxt = 1'b1;
                    timer16_pkg::ACT_TOGGLE: bit_nxt = i_toggle_ok ? !o_bit : o_bit;
                    default: bit_nxt = o_bit;
                endcase
            end
            if (i_bottom) begin
                case (i_action)
                    timer16_pkg::ACT_PWM_NONINV: bit_nxt = 1'b1;
                    timer16_pkg::ACT_PWM_INV: bit_nxt = 1'b0;
                    default: bit_nxt = bit_nxt;
                endcase
            end
        end
    end

    // output bit cleared by reset whatever the pin does
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_bit <= 1'b0;
        end else if (i_ce) begin
            o_bit <= bit_nxt;
        end
    end
endmodule : timer16_out_channel

// File: verification/timer16_compare_output_modes_assertions.sv
// checker of bus handshake, flag and pin behaviour at the timer ports
`timescale 1ns/1ps
module timer16_compare_output_modes_assertions (
    // clock, reset and bus
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // flags and pins
    input wire timer16_pkg::flags_t i_flag_serviced,
    input wire timer16_pkg::flags_t o_flags,
    input wire logic [1:0] o_pin_out,
    input wire logic [1:0] o_pin_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // port register write at its answer edge; any flag register write
    wire logic port_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h1C;
    wire logic flag_wr = i_avs_write && i_avs_address == 5'h14;
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> ##[0:1] !o_avs_waitrequest) else $error("bus answer late");
    a_wait_pulse: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("answer without request");
    a_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data moved without read");
    a_flags_sticky: assert property (!flag_wr |=> ((o_flags & $past(o_flags & ~i_flag_serviced))
        == $past(o_flags & ~i_flag_serviced))) else $error("flag lost without service");
    a_reset_pins: assert property ($rose(i_rstn) |-> o_pin_out == 2'h0
        && o_pin_oe == 2'h0 && o_flags == 4'h0) else $error("pins not cleared by reset");
    a_reset_bus: assert property ($rose(i_rstn) |-> o_avs_waitrequest
        && o_avs_readdata == 32'h0) else $error("bus not idle after reset");
    a_oe_by_write: assert property ($changed(o_pin_oe) |-> $past(port_wr, 1)
        || $past(port_wr, 2)) else $error("direction moved without write");
endmodule : timer16_compare_output_modes_assertions

// File: verification/timer16_pin_model.sv
// port pad with pull-up resolving the pin wire level
`timescale 1ns/1ps
module timer16_pin_model (
    // drive from the timer
    input wire logic [1:0] i_pin_out,
    input wire logic [1:0] i_pin_oe,
    // wire level
    output logic [1:0] o_level
);
    // undriven pin floats to pull-up, never keeps the last value
    assign o_level = (i_pin_out & i_pin_oe) | ~i_pin_oe;
endmodule : timer16_pin_model

// File: verification/tb_timer16_compare_output_modes.sv
// self-checking bench for the compare output timer
`timescale 1ns/1ps
module tb_timer16_compare_output_modes;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
    logic [4:0] adr = 5'h00;
    logic cap = 1'b0;
    logic [31:0] wd = 32'h0, rdata, cnt, top;
    logic [31:0] expq[$];
    timer16_pkg::flags_t svc = 4'h0, flags;
    logic [1:0] pout, poe, lvl;
    int miscompares = 0, compares = 0;
    timer16_compare_output_modes i_timer16_compare_output_modes (.i_clk_sys(clk),
        .i_rstn(rstn), .i_ce(1'b1), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_capture_event(cap),
        .i_flag_serviced(svc), .o_flags(flags), .o_pin_out(pout), .o_pin_oe(poe));
    timer16_pin_model i_timer16_pin_model (.i_pin_out(pout), .i_pin_oe(poe), .o_level(lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            chk(32'h1, 32'h0);
            tally_and_finish();
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rdx
    // cycles until pin a changes level, bounded
    task automatic edge_gap(output logic [31:0] c);
        logic last;
        last = lvl[0];
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (lvl[0] === last && c < 20000);
        if (c >= 20000) begin
            chk(32'h1, 32'h0);
            tally_and_finish();
        end
    endtask : edge_gap
    // read answers compared against the oldest note
    always @(posedge clk) begin
        if (rd && wreq === 1'b0 && expq.size() > 0) chk(rdata, expq.pop_front());
    end
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        logic [1:0] acts[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
        logic [31:0] pins[5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
        logic [31:0] runs[2] = '{32'h94, 32'hA4};
        logic [31:0] divs[2] = '{32'h1, 32'h8};
        void'($urandom(9944));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({30'h0, lvl}, 32'h3);
        rdx(5'h02, 32'h0);
        bus(1'b1, timer16_pkg::OFS_CMP_A, 32'h8000);
        bus(1'b1, timer16_pkg::OFS_CMP_B, 32'h8000);
        bus(1'b1, timer16_pkg::OFS_COUNT, 32'hFFFD);
        bus(1'b1, timer16_pkg::OFS_CTRL, 32'h10);
        repeat (8) @(posedge clk);
        rdx(timer16_pkg::OFS_FLAGS, 32'h1);
        svc <= 4'h1;
        @(posedge clk);
        svc <= 4'h0;
        rdx(timer16_pkg::OFS_FLAGS, 32'h0);
        bus(1'b1, timer16_pkg::OFS_PORT, 32'h4);
        // toggle period on a random top, prescaler 1 then 8
        for (int i = 0; i < 2; i++) begin
            top = 32'h2 + ($urandom % 5);
            bus(1'b1, timer16_pkg::OFS_CTRL, 32'h84);
            bus(1'b1, timer16_pkg::OFS_CMP_A, top);
            bus(1'b1, timer16_pkg::OFS_COUNT, 32'h0);
            bus(1'b1, timer16_pkg::OFS_FLAGS, 32'hF);
            bus(1'b1, timer16_pkg::OFS_CTRL, runs[i]);
            edge_gap(cnt);
            edge_gap(cnt);
            chk(cnt, divs[i] * (top + 32'h1));
            rdx(timer16_pkg::OFS_FLAGS, 32'h2);
        end
        // forced actions with the timer stopped in normal mode
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, timer16_pkg::OFS_CTRL, {23'h0, acts[i], 7'h0});
            bus(1'b1, timer16_pkg::OFS_FORCE, 32'h1);
            repeat (3) @(posedge clk);
            chk({31'h0, lvl[0]}, pins[i]);
        end
        // capture of a random stopped count while action field a is nonzero
        top = $urandom & 32'hFFFF;
        bus(1'b1, timer16_pkg::OFS_COUNT, top);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        rdx(timer16_pkg::OFS_CAPT, top);
        // fast pwm, fixed top 0x00FF, non-inverting, random compare
        top = 32'h10 + ($urandom % 128);
        bus(1'b1, timer16_pkg::OFS_CMP_A, top);
        bus(1'b1, timer16_pkg::OFS_COUNT, 32'h0);
        bus(1'b1, timer16_pkg::OFS_FLAGS, 32'hF);
        bus(1'b1, timer16_pkg::OFS_CTRL, 32'h115);
        edge_gap(cnt);
        edge_gap(cnt);
        chk(cnt, top + 32'h1);
        edge_gap(cnt);
        chk(cnt, 32'hFF - top);
        rdx(timer16_pkg::OFS_FLAGS, 32'h3);
        // reset in mid-run with the output bit high
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b1, timer16_pkg::OFS_PORT, 32'h5);
        bus(1'b1, timer16_pkg::OFS_CTRL, 32'h100);
        repeat (2) @(posedge clk);
        chk({31'h0, lvl[0]}, 32'h0);
        tally_and_finish();
    end
endmodule : tb_timer16_compare_output_modes
bind timer16_compare_output_modes timer16_compare_output_modes_assertions i_chk (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_flag_serviced(i_flag_serviced),
    .o_flags(o_flags), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
